/* cis_pkg.sv */
// Package for the capture interrupt status collector.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package cis_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_STATUS = 12'h100;
    localparam logic [11:0] OFF_MASK   = 12'h104;
    localparam logic [11:0] OFF_CTRL   = 12'h108;

    // Status word field positions
    localparam int POS_PSTAT_LO = 28;
    localparam int POS_RUNNING  = 27;
    localparam int POS_ACK      = 25;
    localparam int POS_FIELD    = 24;
    localparam int POS_SYNCERR  = 19;
    localparam int POS_OPCODE   = 18;
    localparam int POS_ABORT    = 17;
    localparam int POS_IPAR     = 16;
    localparam int POS_BPAR     = 15;
    localparam int POS_RESYNC   = 14;
    localparam int POS_TLAT     = 13;
    localparam int POS_DROP     = 12;
    localparam int POS_PIRQ     = 11;
    localparam int POS_GPIN     = 9;
    localparam int POS_SDONE    = 8;
    localparam int POS_VIDEO_PRESENCE_CHANGE    = 5;
    localparam int POS_HORIZONTAL_LOCK_CHANGE    = 4;
    localparam int POS_CONVERTER_OVERFLOW    = 3;
    localparam int POS_LINE     = 2;
    localparam int POS_FLDCHG   = 1;
    localparam int POS_FMT      = 0;

    // Control register field positions
    localparam int POS_DMA_EN   = 0;
    localparam int POS_PER_EN   = 1;
    localparam int POS_GP_EDGE  = 2;
    localparam int POS_GP_INV   = 3;

    // Event flags that may interrupt (bits 23:0, reserved ones zero)
    localparam logic [23:0] EVENT_BITS = 24'h0ffb3f;

    // Reset values
    localparam logic [23:0] RST_MASK   = 24'h000000;
    localparam logic [23:0] RST_FLAGS  = 24'h000000;
    localparam logic [3:0]  RST_PSTAT  = 4'h0;
    localparam logic [3:0]  RST_CTRL   = 4'h0;

    // Event inputs from the surrounding sources, one-cycle pulses or levels
    typedef struct packed {
        logic sync_overflow;
        logic sync_mismatch;
        logic bad_opcode;
        logic bad_sync_status;
        logic instr_error;
        logic master_abort;
        logic target_abort;
        logic instr_fetch_parity;
        logic bus_parity;
        logic stream_mismatch;
        logic overrun_latency;
        logic overrun_drop;
        logic instr_irq;
        logic serial_done;
        logic serial_acked;
        logic video_presence;
        logic horizontal_lock_change_state;
        logic luma_overflow;
        logic chroma_overflow;
        logic line_start;
        logic line_reset_input;
        logic field_change;
        logic format_switch;
    } cis_events_t;

    // DMA instruction status update
    typedef struct packed {
        logic       exec;
        logic [3:0] set_bits;
        logic [3:0] reset_bits;
    } cis_prog_t;

endpackage : cis_pkg

/* cis_status.sv */
// Capture interrupt status collector: sticky event flags, live status,
// enable mask and a level interrupt, behind a classic Wishbone slave.
// Assumes event inputs are synchronous one-cycle pulses or levels on clk_i.
`timescale 1ns/1ns

module cis_status (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [11:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Event sources
    input  wire cis_pkg::cis_events_t ev_i,
    input  wire cis_pkg::cis_prog_t   prog_i,
    input  wire logic                 general_interrupt_pin_i,
    input  wire logic                 even_field_i,
    // Control to the DMA engine
    output logic                      dma_program_enable_o,
    output logic                      parity_response_o,
    // Bus interrupt, active high level
    output logic                      irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    logic        req;
    logic        wr;
    logic        hit_stat;
    logic        hit_mask;
    logic        hit_ctrl;
    logic [31:0] wmask;
    logic [31:0] rdata;

    // One request per handshake; ack drops the cycle after it is given.
    // A write lands on the edge where the master samples ack high, so a
    // master that gives up before the ack never changes any register.
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr       = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    assign hit_stat = (wb_adr_i == cis_pkg::OFF_STATUS);
    assign hit_mask = (wb_adr_i == cis_pkg::OFF_MASK);
    assign hit_ctrl = (wb_adr_i == cis_pkg::OFF_CTRL);
    assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [23:0] flags_r;
    logic [23:0] flags_nxt;
    logic [23:0] set_ev;
    logic [23:0] mask_r;
    logic [3:0]  pstat_r;
    logic [3:0]  ctrl_r;
    logic        ack_r;
    logic        horizontal_lock_change_r;
    logic        video_presence_change_r;
    logic        lreset_r;
    logic        gp_r;
    logic        gp_in;

    // Control bits, software writes, parity fault clears enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= cis_pkg::RST_CTRL;
        end else begin
            if (wr && hit_ctrl && wb_sel_i[0])
                ctrl_r <= wb_dat_i[3:0];
            if (ev_i.instr_fetch_parity && ctrl_r[cis_pkg::POS_PER_EN])
                ctrl_r[cis_pkg::POS_DMA_EN] <= 1'b0;
        end
    end

    // Enable mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= cis_pkg::RST_MASK;
        end else if (wr && hit_mask) begin
            mask_r <= (mask_r & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
        end
    end

    // Previous values for change and edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            horizontal_lock_change_r  <= 1'b0;
            video_presence_change_r  <= 1'b0;
            lreset_r <= 1'b0;
            gp_r     <= 1'b0;
        end else begin
            horizontal_lock_change_r  <= ev_i.horizontal_lock_change_state;
            video_presence_change_r  <= ev_i.video_presence;
            lreset_r <= ev_i.line_reset_input;
            gp_r     <= gp_in;
        end
    end

    // Pin optionally inverted, then level or rising edge
    assign gp_in = general_interrupt_pin_i ^ ctrl_r[cis_pkg::POS_GP_INV];

    // Event set terms per flag position
    always_comb begin
        set_ev = '0;
        set_ev[cis_pkg::POS_SYNCERR] = ev_i.sync_overflow
                                     | ev_i.sync_mismatch;
        set_ev[cis_pkg::POS_OPCODE]  = ev_i.bad_opcode | ev_i.instr_error
                                     | ev_i.bad_sync_status;
        set_ev[cis_pkg::POS_ABORT]   = ev_i.master_abort
                                     | ev_i.target_abort;
        set_ev[cis_pkg::POS_IPAR]    = ev_i.instr_fetch_parity
                                     & ctrl_r[cis_pkg::POS_PER_EN];
        set_ev[cis_pkg::POS_BPAR]    = ev_i.bus_parity;
        set_ev[cis_pkg::POS_RESYNC]  = ev_i.stream_mismatch;
        set_ev[cis_pkg::POS_TLAT]    = ev_i.overrun_latency;
        set_ev[cis_pkg::POS_DROP]    = ev_i.overrun_drop;
        set_ev[cis_pkg::POS_PIRQ]    = prog_i.exec
                                     & ev_i.instr_irq;
        set_ev[cis_pkg::POS_GPIN]    = ctrl_r[cis_pkg::POS_GP_EDGE]
                                     ? (gp_in & ~gp_r) : gp_in;
        set_ev[cis_pkg::POS_SDONE]   = ev_i.serial_done;
        set_ev[cis_pkg::POS_VIDEO_PRESENCE_CHANGE]   = ev_i.video_presence
                                     ^ video_presence_change_r;
        set_ev[cis_pkg::POS_HORIZONTAL_LOCK_CHANGE]   = ev_i.horizontal_lock_change_state ^ horizontal_lock_change_r;
        set_ev[cis_pkg::POS_CONVERTER_OVERFLOW]   = ev_i.luma_overflow
                                     | ev_i.chroma_overflow;
        set_ev[cis_pkg::POS_LINE]    = ev_i.line_start
                                     | (ev_i.line_reset_input
                                        & ~lreset_r);
        set_ev[cis_pkg::POS_FLDCHG]  = ev_i.field_change;
        set_ev[cis_pkg::POS_FMT]     = ev_i.format_switch;
    end

    // Sticky flags: write-one clears, a same-cycle event wins
    always_comb begin
        flags_nxt = flags_r;
        if (wr && hit_stat)
            flags_nxt = flags_r & ~(wb_dat_i[23:0] & wmask[23:0]);
        flags_nxt = (flags_nxt | set_ev) & cis_pkg::EVENT_BITS;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            flags_r <= cis_pkg::RST_FLAGS;
        else
            flags_r <= flags_nxt;
    end

    // Program status bits from executed instructions, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i)
            pstat_r <= cis_pkg::RST_PSTAT;
        else if (prog_i.exec)
            pstat_r <= (pstat_r & ~prog_i.reset_bits)
                     | prog_i.set_bits;
    end

    // Serial acknowledge status, cleared by an unacknowledged finish
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ack_r <= 1'b0;
        else if (ev_i.serial_done)
            ack_r <= ev_i.serial_acked;
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux; status word reads at any time, without side effects
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_stat) begin
            rdata[31:28] = pstat_r;
            rdata[cis_pkg::POS_RUNNING] = ctrl_r[cis_pkg::POS_DMA_EN];
            rdata[cis_pkg::POS_ACK]     = ack_r;
            rdata[cis_pkg::POS_FIELD]   = even_field_i;
            rdata[23:0] = flags_r;
        end else if (hit_mask) begin
            rdata[23:0] = mask_r;
        end else if (hit_ctrl) begin
            rdata[3:0] = ctrl_r;
        end
    end

    // Ack every access one cycle after request; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r_bus: wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_we_i)
            wb_dat_o <= rdata;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs; interrupt combinational so unmasking acts at once
    assign irq_o = |(flags_r & mask_r);
    assign dma_program_enable_o = ctrl_r[cis_pkg::POS_DMA_EN];
    assign parity_response_o    = ctrl_r[cis_pkg::POS_PER_EN];

endmodule : cis_status

/* cis_host_model.sv */
// Host driver model: classic Wishbone single cycles.
// Assumes the slave acks each taken request once.
`timescale 1ns/1ns

module cis_host_model (
    // Clock and answer
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    // Request
    output logic             cyc_o,
    output logic             we_o,
    output logic      [11:0] adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o
);
    ////////////////////////////////////////
    // Idle bus from time zero
    initial begin
        cyc_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 12'h000;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end

    // Request held until ack; data inverted on release so stale
    // write data never looks valid
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [3:0] s, input logic [31:0] d,
                        output logic [31:0] q);
        cyc_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask : xfer
endmodule : cis_host_model

/* cis_status_assertions.sv */
// Port checker for the interrupt status collector.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns

module cis_status_assertions (
    // Clock, reset and bus
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [11:0]          wb_adr_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    // Events and outputs
    input wire cis_pkg::cis_events_t ev_i,
    input wire logic                 even_field_i,
    input wire logic                 dma_program_enable_o,
    input wire logic                 parity_response_o,
    input wire logic                 irq_o
);
    ////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // A request is taken only while ack is low
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd;
        s_take ##0 !wb_we_i && wb_adr_i == cis_pkg::OFF_STATUS;
    endsequence

    property p_ack;
        s_take |=> wb_ack_o;
    endproperty
    property p_ack1;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    // Only a bus write may drop a standing interrupt
    property p_lvl;
        irq_o && !(wb_cyc_i && wb_we_i) |=> irq_o;
    endproperty
    property p_run;
        s_rd ##0 !dma_program_enable_o |=> !wb_dat_o[27];
    endproperty
    property p_rsv;
        s_rd |=> (wb_dat_o & 32'h04f004c0) == 32'h0;
    endproperty
    property p_fld;
        s_rd |=> wb_dat_o[24] == $past(even_field_i);
    endproperty
    property p_halt;
        parity_response_o && ev_i.instr_fetch_parity
            |=> !dma_program_enable_o;
    endproperty
    property p_par;
        ev_i.bus_parity ##1 s_rd |=> wb_dat_o[15];
    endproperty

    a_ack: assert property (p_ack) else $error("ack late");
    a_ack1: assert property (p_ack1) else $error("ack long");
    a_lvl: assert property (p_lvl) else $error("irq dropped");
    a_run: assert property (p_run) else $error("run bit set");
    a_rsv: assert property (p_rsv) else $error("reserved set");
    a_fld: assert property (p_fld) else $error("field bit");
    a_halt: assert property (p_halt) else $error("no halt");
    a_par: assert property (p_par) else $error("parity flag");
endmodule : cis_status_assertions

bind cis_status cis_status_assertions u_chk (.*);

/* cis_status_test.sv */
// Self-checking bench: directed and random events, host reads.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns

module cis_status_test;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic general_interrupt_pin_i, even_field_i, ak;
    logic dma_program_enable_o, parity_response_o;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i, ps;
    logic [31:0] wb_dat_i, wb_dat_o, q, ex, w, seed;
    logic [23:0] cf;
    cis_pkg::cis_events_t ev_i;
    cis_pkg::cis_prog_t   prog_i;
    int errors, samples_checked, cycles;
    // Status bit raised by each event input, -1 for none
    int pos [23] = '{0, 1, 2, 2, 3, 3, 4, 5, -1, 8, 11, 12, 13, 14, 15,
                     16, 17, 17, 18, 18, 18, 19, 19};
    ////////////////////////////////////////
    assign wb_stb_i = wb_cyc_i;
    cis_status u_dut (.*);
    cis_host_model u_host (.clk_i(clk_i), .ack_i(wb_ack_o),
        .dat_i(wb_dat_o), .cyc_o(wb_cyc_i), .we_o(wb_we_i),
        .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // Expected flags; x is exec, p is parity response
    function automatic logic [23:0] flg(input logic [22:0] e,
                                        input logic x, input logic p);
        logic [23:0] f;
        f = 24'h0;
        for (int i = 0; i < 23; i++) begin
            if (e[i] && pos[i] >= 0 && (i != 10 || x) && (i != 15 || p))
                f[pos[i]] = 1'b1;
        end
        return f;
    endfunction : flg

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic rw(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        u_host.xfer(w, a, 4'hf, d, q);
    endtask : rw

    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Hang guard, well above the roughly 600 cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 8000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        rst_i = 1'b1;
        ev_i = '0;
        prog_i = '0;
        general_interrupt_pin_i = 1'b0;
        even_field_i = 1'b0;
        seed = 32'h0000b865;
        cf = 24'h0;
        ps = 4'h0;
        ak = 1'b0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, unmapped space, byte-gated mask write
        rw(1'b0, cis_pkg::OFF_STATUS, 32'h0);
        chk("status", 32'h0, q);
        rw(1'b0, 12'h1fc, 32'h0);
        chk("unmapped", 32'h0, q);
        u_host.xfer(1'b1, cis_pkg::OFF_MASK, 4'h1, 32'hffffffff, q);
        rw(1'b0, cis_pkg::OFF_MASK, 32'h0);
        chk("mask", 32'h000000ff, q);
        // Every event alone, all enabled, parity response on
        rw(1'b1, cis_pkg::OFF_MASK, {8'h0, cis_pkg::EVENT_BITS});
        rw(1'b1, cis_pkg::OFF_CTRL, 32'h3);
        for (int i = 0; i < 23; i++) begin
            ev_i <= 23'h1 << i;
            prog_i.exec <= (i == 10);
            @(posedge clk_i);
            ev_i <= '0;
            prog_i.exec <= 1'b0;
            rw(1'b0, cis_pkg::OFF_STATUS, 32'h0);
            chk("flags", flg(23'h1 << i, 1'b1, 1'b1), q[23:0]);
            chk("running", 32'(i < 15), 32'(q[27]));
            chk("irq", 32'(i != 8), 32'(irq_o));
            rw(1'b1, cis_pkg::OFF_STATUS, q);
            chk("irq", 32'h0, 32'(irq_o));
        end
        chk("halt", 32'h0, 32'(dma_program_enable_o));
        // Random events, program status, masks and partial clears
        rw(1'b1, cis_pkg::OFF_CTRL, 32'h0);
        repeat (40) begin
            seed = xs(seed);
            ev_i <= seed[22:0];
            prog_i <= {seed[23], seed[27:24], seed[31:28] & ~seed[27:24]};
            general_interrupt_pin_i <= seed[29];
            even_field_i <= seed[30];
            if (seed[23]) ps = (ps & ~seed[31:28]) | seed[27:24];
            if (seed[9]) ak = seed[8];
            ex = {ps, 2'b00, ak, seed[30], cf | (24'(seed[29]) << 9)
                  | flg(seed[22:0], seed[23], 1'b0)};
            @(posedge clk_i);
            ev_i <= '0;
            prog_i <= '0;
            general_interrupt_pin_i <= 1'b0;
            seed = xs(seed);
            rw(1'b1, cis_pkg::OFF_MASK, seed);
            rw(1'b0, cis_pkg::OFF_STATUS, 32'h0);
            chk("status", ex, q);
            chk("irq", 32'(|(ex[23:0] & seed[23:0])), 32'(irq_o));
            w = q & {seed[7:0], seed[31:8]};
            cf = q[23:0] & ~w[23:0];
            rw(1'b1, cis_pkg::OFF_STATUS, w);
        end
        wrap_up();
    end
endmodule : cis_status_test
